// [inc/fasd_pkg.sv]
// Package for the flash identification host controller
package fasd_pkg;
  localparam int ADDR_W = 22;
  localparam int SECT_W = 7;
  localparam int SECT_LSB = 15;
  localparam int CODE_W = 8;
  localparam int SEL_W = 3;
  // Selector codes requested by the user
  localparam logic [2:0] SEL_MAKER = 3'h0;
  localparam logic [2:0] SEL_DEV1 = 3'h1;
  localparam logic [2:0] SEL_DEV2 = 3'h2;
  localparam logic [2:0] SEL_DEV3 = 3'h3;
  localparam logic [2:0] SEL_PROT = 3'h4;
  localparam logic [2:0] SEL_SECSI = 3'h5;
  // Selector address pin positions
  localparam int PIN_A0 = 0;
  localparam int PIN_A1 = 1;
  localparam int PIN_A2 = 2;
  localparam int PIN_A3 = 3;
  localparam int PIN_A6 = 6;
  // Command register words for in-system identification
  localparam logic [21:0] CMD_ADDR1 = 22'h000555;
  localparam logic [21:0] CMD_ADDR2 = 22'h0002AA;
  localparam logic [7:0] CMD_DATA1 = 8'hAA;
  localparam logic [7:0] CMD_DATA2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [21:0] ADDR_ZERO = 22'h000000;
  localparam logic [7:0] PROT_YES = 8'h01;
  // Timing: setup before sampling, pulse widths
  localparam int CLK_NS = 50;
  localparam int T_SETUP_NS = 100;
  localparam int T_WP_NS = 100;
  localparam int T_HV_NS = 500;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HV_CYC = (T_HV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [1:0] STEP_ZERO = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_LAST = 2'h2;
  localparam logic [1:0] STEP_EXIT = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE, ST_HV_ON, ST_ADDR, ST_SAMPLE, ST_CMD_ADDR, ST_CMD_WE, ST_CMD_GAP, ST_EXIT, ST_DONE
  } fasd_state_t;
endpackage

// [src/fasd_addr_build.sv]
// Builds the identification read address from a selector and sector
`timescale 1ns/100ps
module fasd_addr_build (
  // Request
  input wire logic [2:0] sel,
  input wire logic [6:0] sector,
  // Address to the device
  output logic [21:0] addr
);
  always_comb
  begin
    // Unused address bits held low; the device ignores them
    addr = fasd_pkg::ADDR_ZERO;
    case (sel)
      fasd_pkg::SEL_MAKER:
      begin
      end
      fasd_pkg::SEL_DEV1:
      begin
        addr[fasd_pkg::PIN_A0] = 1'b1;
      end
      fasd_pkg::SEL_DEV2:
      begin
        addr[fasd_pkg::PIN_A1] = 1'b1;
        addr[fasd_pkg::PIN_A2] = 1'b1;
        addr[fasd_pkg::PIN_A3] = 1'b1;
      end
      fasd_pkg::SEL_DEV3:
      begin
        addr[fasd_pkg::PIN_A0] = 1'b1;
        addr[fasd_pkg::PIN_A1] = 1'b1;
        addr[fasd_pkg::PIN_A2] = 1'b1;
        addr[fasd_pkg::PIN_A3] = 1'b1;
      end
      fasd_pkg::SEL_PROT:
      begin
        addr[fasd_pkg::PIN_A1] = 1'b1;
        addr[fasd_pkg::SECT_LSB +: fasd_pkg::SECT_W] = sector;
      end
      fasd_pkg::SEL_SECSI:
      begin
        addr[fasd_pkg::PIN_A0] = 1'b1;
        addr[fasd_pkg::PIN_A1] = 1'b1;
      end
      default:
      begin
      end
    endcase
  end
endmodule

// [src/fasd_host.sv]
// Host controller reading flash identification codes
`timescale 1ns/100ps
// Summary of operation
// - Identification high voltage on its pin enables the mode.
// - Host holds selector address pins at the wanted code's levels.
// - Host places sector address on top bits for protection reads.
// - Command register entry gives the codes without high voltage.
// - Host samples the code only after address and voltage settle.
module fasd_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // User request
  input wire logic req,
  input wire logic use_cmd,
  input wire logic [2:0] sel,
  input wire logic [6:0] sector,
  output logic busy,
  output logic done,
  output logic [7:0] code,
  output logic sect_protected,
  // Flash pins
  output logic [21:0] flash_addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic high_voltage_select_pin,
  input wire logic [7:0] low_data_byte_in,
  output logic [7:0] low_data_byte_out,
  output logic low_data_byte_oe
);
  fasd_pkg::fasd_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [1:0] step_q, step_d;
  logic use_cmd_q, use_cmd_d;
  logic [2:0] sel_q, sel_d;
  logic [6:0] sector_q, sector_d;
  logic [21:0] addr_q, addr_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic hv_q, hv_d;
  logic [7:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic busy_q, busy_d, done_q, done_d;
  logic [7:0] code_q, code_d;
  logic prot_q, prot_d;
  logic [21:0] id_addr;

  fasd_addr_build u_addr (
    .sel(sel_q),
    .sector(sector_q),
    .addr(id_addr)
  );

  function automatic logic [4:0] cyc(input int n);
    cyc = n[4:0];
  endfunction

  function automatic logic [21:0] cmd_addr(input logic [1:0] s);
    cmd_addr = (s == fasd_pkg::STEP_ONE) ? fasd_pkg::CMD_ADDR2 : fasd_pkg::CMD_ADDR1;
  endfunction

  function automatic logic [7:0] cmd_data(input logic [1:0] s, input logic ex);
    if (ex)
      cmd_data = fasd_pkg::CMD_RESET;
    else if (s == fasd_pkg::STEP_ZERO)
      cmd_data = fasd_pkg::CMD_DATA1;
    else if (s == fasd_pkg::STEP_ONE)
      cmd_data = fasd_pkg::CMD_DATA2;
    else
      cmd_data = fasd_pkg::CMD_AUTOSEL;
  endfunction

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    step_d = step_q;
    use_cmd_d = use_cmd_q;
    sel_d = sel_q;
    sector_d = sector_q;
    addr_d = addr_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    hv_d = hv_q;
    dout_d = dout_q;
    doe_d = doe_q;
    busy_d = busy_q;
    done_d = 1'b0;
    code_d = code_q;
    prot_d = prot_q;
    case (st_q)
      fasd_pkg::ST_IDLE:
      begin
        if (req)
        begin
          use_cmd_d = use_cmd;
          sel_d = sel;
          sector_d = sector;
          busy_d = 1'b1;
          step_d = fasd_pkg::STEP_ZERO;
          if (use_cmd)
            st_d = fasd_pkg::ST_CMD_ADDR;
          else
          begin
            hv_d = 1'b1;
            cnt_d = cyc(fasd_pkg::HV_CYC);
            st_d = fasd_pkg::ST_HV_ON;
          end
        end
      end
      fasd_pkg::ST_HV_ON:
      begin
        cnt_d = cnt_q - fasd_pkg::CNT_ONE;
        if (cnt_q == fasd_pkg::CNT_ONE)
          st_d = fasd_pkg::ST_ADDR;
      end
      fasd_pkg::ST_ADDR:
      begin
        addr_d = id_addr;
        ce_n_d = 1'b0;
        oe_n_d = 1'b0;
        we_n_d = 1'b1;
        doe_d = 1'b0;
        cnt_d = cyc(fasd_pkg::SETUP_CYC);
        st_d = fasd_pkg::ST_SAMPLE;
      end
      fasd_pkg::ST_SAMPLE:
      begin
        cnt_d = cnt_q - fasd_pkg::CNT_ONE;
        if (cnt_q == fasd_pkg::CNT_ONE)
        begin
          code_d = low_data_byte_in;
          prot_d = (sel_q == fasd_pkg::SEL_PROT) && (low_data_byte_in == fasd_pkg::PROT_YES);
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          hv_d = 1'b0;
          addr_d = fasd_pkg::ADDR_ZERO;
          if (use_cmd_q)
          begin
            step_d = fasd_pkg::STEP_EXIT;
            st_d = fasd_pkg::ST_CMD_ADDR;
          end
          else
            st_d = fasd_pkg::ST_DONE;
        end
      end
      fasd_pkg::ST_CMD_ADDR:
      begin
        // Exit uses reset word so the array reads normally again
        addr_d = cmd_addr(step_q);
        dout_d = cmd_data(step_q, step_q == fasd_pkg::STEP_EXIT);
        doe_d = 1'b1;
        ce_n_d = 1'b0;
        oe_n_d = 1'b1;
        we_n_d = 1'b0;
        cnt_d = cyc(fasd_pkg::WP_CYC);
        st_d = fasd_pkg::ST_CMD_WE;
      end
      fasd_pkg::ST_CMD_WE:
      begin
        cnt_d = cnt_q - fasd_pkg::CNT_ONE;
        if (cnt_q == fasd_pkg::CNT_ONE)
        begin
          we_n_d = 1'b1;
          ce_n_d = 1'b1;
          st_d = fasd_pkg::ST_CMD_GAP;
        end
      end
      fasd_pkg::ST_CMD_GAP:
      begin
        doe_d = 1'b0;
        if (step_q == fasd_pkg::STEP_EXIT)
          st_d = fasd_pkg::ST_DONE;
        else if (step_q == fasd_pkg::STEP_LAST)
          st_d = fasd_pkg::ST_ADDR;
        else
        begin
          step_d = step_q + fasd_pkg::STEP_ONE;
          st_d = fasd_pkg::ST_CMD_ADDR;
        end
      end
      fasd_pkg::ST_DONE:
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        st_d = fasd_pkg::ST_IDLE;
      end
      default:
      begin
        st_d = fasd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= fasd_pkg::ST_IDLE;
      cnt_q <= fasd_pkg::CNT_ZERO;
      step_q <= fasd_pkg::STEP_ZERO;
      use_cmd_q <= 1'b0;
      sel_q <= fasd_pkg::SEL_MAKER;
      sector_q <= 7'h00;
      addr_q <= fasd_pkg::ADDR_ZERO;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      hv_q <= 1'b0;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      code_q <= 8'h00;
      prot_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      use_cmd_q <= use_cmd_d;
      sel_q <= sel_d;
      sector_q <= sector_d;
      addr_q <= addr_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      hv_q <= hv_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      busy_q <= busy_d;
      done_q <= done_d;
      code_q <= code_d;
      prot_q <= prot_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign code = code_q;
  assign sect_protected = prot_q;
  assign flash_addr = addr_q;
  assign ce_n = ce_n_q;
  assign oe_n = oe_n_q;
  assign we_n = we_n_q;
  assign high_voltage_select_pin = hv_q;
  assign low_data_byte_out = dout_q;
  assign low_data_byte_oe = doe_q;
endmodule

// [verif/fasd_host_chk.sv]
// Port assertions for the identification host controller
`timescale 1ns/100ps
module fasd_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Watched outputs
  input wire logic busy,
  input wire logic done,
  input wire logic [21:0] flash_addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic high_voltage_select_pin,
  input wire logic low_data_byte_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd_open;
    $fell(oe_n) ##0 high_voltage_select_pin;
  endsequence
  sequence s_op_end;
    ##[12:40] done;
  endsequence
  chk_rd_strobes: assert property (!oe_n |-> !ce_n && we_n && !low_data_byte_oe)
    else $error("read strobes wrong");
  chk_hv_settle: assert property (s_rd_open |-> $past(high_voltage_select_pin, 10))
    else $error("read before voltage settled");
  chk_op_bound: assert property ($rose(busy) |-> s_op_end)
    else $error("operation did not end in time");
  chk_done_busy: assert property (done |-> !busy && $past(busy))
    else $error("done without busy");
  chk_sel_low: assert property (!oe_n |-> !flash_addr[6])
    else $error("selector pin high in read");
  chk_addr_hold: assert property (!oe_n && !$past(oe_n) |-> $stable(flash_addr))
    else $error("address moved during read");
  chk_cmd_no_hv: assert property (!we_n |-> !high_voltage_select_pin && low_data_byte_oe && oe_n)
    else $error("command write malformed");
  chk_we_width: assert property ($fell(we_n) |-> ##1 !we_n)
    else $error("write pulse too short");
  chk_hv_drop: assert property ($fell(high_voltage_select_pin) |-> ##1 done)
    else $error("voltage dropped without done");
  chk_idle_quiet: assert property (!busy |-> ce_n && !high_voltage_select_pin)
    else $error("pins active while idle");
endmodule

// [verif/fasd_flash_model.sv]
// Behavioural flash device answering identification reads
`timescale 1ns/100ps
module fasd_flash_model #(
  // Arbitrary identification values
  parameter logic [7:0] MK = 8'hA5,
  parameter logic [7:0] D1 = 8'h3C,
  parameter logic [7:0] D2 = 8'h5A,
  parameter logic [7:0] D3 = 8'h66,
  parameter logic [7:0] SX = 8'h2B
) (
  // Flash pins
  input wire logic [21:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv,
  input wire logic [7:0] wdata,
  output logic [7:0] dq,
  // Address of the last answered read
  output logic [21:0] rd_addr
);
  logic [1:0] step = 2'h0;
  logic cmd_mode = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] id;
  logic wr_n;
  // Write ends at whichever strobe rises first; the host may raise both together
  assign wr_n = we_n | ce_n;
  // No program path at all, so protected groups never change
  always @(posedge wr_n)
  begin
    if (!$isunknown({addr, wdata}))
    begin
      if (wdata == 8'hF0)
        cmd_mode = 1'b0;
      else if (step == 2'h2 && wdata == 8'h90 && addr[10:0] == 11'h555)
        cmd_mode = 1'b1;
      step = (wdata == 8'hAA && addr[10:0] == 11'h555) ? 2'h1 :
        (step == 2'h1 && wdata == 8'h55 && addr[10:0] == 11'h2AA) ? 2'h2 : 2'h0;
    end
  end
  // Other address bits are never looked at, except addr[15] for the protection code
  always_comb
  begin
    case ({addr[6], addr[3:0]})
      5'h00: id = MK;
      5'h01: id = D1;
      5'h0E: id = D2;
      5'h0F: id = D3;
      5'h02: id = {7'h00, addr[15]};
      5'h03: id = SX;
      default: id = 8'hFF;
    endcase
  end
  // Released bus shows the inverse of the last byte
  always @(*)
  begin
    if (!ce_n && !oe_n && we_n && (hv || cmd_mode))
    begin
      dq = id;
      last = id;
      rd_addr = addr;
    end
    else
      dq = ~last;
  end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the identification host controller
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic req = 1'b0;
  logic use_cmd = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [6:0] sector = 7'h00;
  logic busy, done, sect_protected, ce_n, oe_n, we_n, hv, dq_oe;
  logic [7:0] code, dq_in, dq_out;
  logic [21:0] flash_addr, rd_addr;
  logic [7:0] lfsr = 8'h18;
  logic [7:0] codes [6] = '{8'hA5, 8'h3C, 8'h5A, 8'h66, 8'h00, 8'h2B};
  logic [4:0] pins [6] = '{5'h00, 5'h01, 5'h0E, 5'h0F, 5'h02, 5'h03};
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #25 mclk = ~mclk;
  fasd_host dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .req(req), .use_cmd(use_cmd),
    .sel(sel), .sector(sector), .busy(busy), .done(done), .code(code),
    .sect_protected(sect_protected), .flash_addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .high_voltage_select_pin(hv), .low_data_byte_in(dq_in),
    .low_data_byte_out(dq_out), .low_data_byte_oe(dq_oe));
  fasd_flash_model flash (.addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .hv(hv),
    .wdata(dq_out), .dq(dq_in), .rd_addr(rd_addr));
  function automatic logic [7:0] step_lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] exp_code(input logic [2:0] s, input logic [6:0] sc);
    return (s == 3'h4) ? {7'h00, sc[0]} : codes[s];
  endfunction
  task automatic chk(input string what, input logic [21:0] e, input logic [21:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic do_read(input logic m, input logic [2:0] s, input logic [6:0] sc,
    input logic poke);
    int n;
    n = 0;
    @(posedge mclk);
    #5;
    req = 1'b1;
    use_cmd = m;
    sel = s;
    sector = sc;
    @(posedge mclk);
    #5;
    req = 1'b0;
    // Second request while busy must be ignored
    if (poke)
    begin
      repeat (3) @(posedge mclk);
      #5;
      req = 1'b1;
      sel = 3'h5 - s;
      @(posedge mclk);
      #5;
      req = 1'b0;
    end
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 60);
    chk("done", 1'b1, done);
    chk("code", exp_code(s, sc), code);
    chk("pins", pins[s], {rd_addr[6], rd_addr[3:0]});
    if (s == 3'h4)
    begin
      chk("sector", sc, rd_addr[21:15]);
    end
    chk("protected", (s == 3'h4) ? sc[0] : 1'b0, sect_protected);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    #5;
    chk("reset ce_n", 1'b1, ce_n);
    chk("reset hv", 1'b0, hv);
    chk("reset busy", 1'b0, busy);
    rstn = 1'b1;
    for (int i = 0; i < 12; i++)
      do_read(i[0], i[3:1], i[0] ? 7'h7F : 7'h00, 1'b0);
    for (int i = 0; i < 20; i++)
    begin
      lfsr = step_lfsr(lfsr);
      do_read(lfsr[7], 3'(lfsr % 6), lfsr[6:0] ^ 7'(i), lfsr[3]);
    end
    // Frozen clock enable must not take a request
    @(posedge mclk);
    #5;
    clk_en = 1'b0;
    req = 1'b1;
    @(posedge mclk);
    #5;
    clk_en = 1'b1;
    req = 1'b0;
    @(posedge mclk);
    #1;
    chk("frozen busy", 1'b0, busy);
    finish_test();
  end
endmodule
bind fasd_host fasd_chk u_chk (.mclk(mclk), .rstn(rstn), .busy(busy), .done(done),
  .flash_addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .high_voltage_select_pin(high_voltage_select_pin), .low_data_byte_oe(low_data_byte_oe));
